// file: rtl/pbcs_basic_regs.v
// basic control and status registers of the transceiver with the MII isolation and test steering they drive
//
// Operation
// - a 1 written to control bit 11 puts the device into its low-power mode.
// - in low-power mode the line pair and all indicators float and the MII is isolated.
// - control bit 10 at 1 isolates the MII while management access keeps working.
// - a 1 written to control bit 9 restarts negotiation and the bit clears itself after the restart.
// - control bit 8 picks full or half duplex and is ignored while bit 12 is set.
// - with control bit 7 set, collision follows transmit enable.
// - software cannot change any bit of the status register.
// - status bit 15 always reads 0.
// - status bits 14 and 13 always read 1.
// - status bits 12 and 11 always read 1.
// - control bit 12 enables negotiation and decides whether manual duplex is honoured.
// - an all-zero strapped address brings the device up isolated through control bit 10.
`timescale 1ns/100ps
`default_nettype none
`include "pbcs_map.vh"

module pbcs_basic_regs (
	// clock and reset
	input  wire        clock_i,
	input  wire        rst_n_i,
	// address strap, valid at reset release
	input  wire [4:0]  phy_addr_i,
	// serial management pins
	input  wire        mdc_i,
	input  wire        mdio_i,
	output wire        mdio_o,
	output wire        mdio_oe_n_o,
	// MII transmit inputs from the mac
	input  wire [3:0]  mii_txd_i,
	input  wire        mii_tx_en_i,
	input  wire        mii_tx_er_i,
	// transmit path towards the core
	output reg  [3:0]  core_txd_o,
	output reg         core_tx_en_o,
	output reg         core_tx_er_o,
	// MII outputs coming from the core
	input  wire        core_tx_clk_i,
	input  wire        core_rx_clk_i,
	input  wire [3:0]  core_rxd_i,
	input  wire        core_rx_dv_i,
	input  wire        core_rx_er_i,
	input  wire        core_col_i,
	input  wire        core_crs_i,
	// MII outputs towards the mac
	output reg         mii_tx_clk_o,
	output reg         mii_rx_clk_o,
	output reg  [3:0]  mii_rxd_o,
	output reg         mii_rx_dv_o,
	output reg         mii_rx_er_o,
	output reg         mii_col_o,
	output reg         mii_crs_o,
	output reg         mii_oe_n_o,
	// line transmit pair
	input  wire        core_line_tx_p_i,
	input  wire        core_line_tx_n_i,
	output reg         line_transmit_pair_p_o,
	output reg         line_transmit_pair_n_o,
	output reg         line_oe_n_o,
	// indicators
	input  wire [4:0]  core_led_i,
	output reg  [4:0]  led_o,
	output reg         led_oe_n_o,
	// negotiation and mode steering
	input  wire        an_full_duplex_i,
	output reg         autoneg_enable_o,
	output reg         autoneg_restart_o,
	output reg         full_duplex_o,
	output reg         power_down_o,
	output reg         isolated_o
);

	// ****************************************
	// control state
	// ****************************************
	reg         autoneg_enable;
	reg         power_down_ctl;
	reg         mii_isolate_ctl;
	reg         restart_autoneg_ctl;
	reg         duplex_select;
	reg         collision_test_ctl;
	reg         strap_taken;
	reg  [4:0]  own_addr;
	reg  [15:0] rd_data;
	reg  [15:0] next_rd_data;
	reg  [15:0] control_word;
	wire [4:0]  reg_addr;
	wire        wr_strobe;
	wire [15:0] wr_data;
	wire        ctl_wr;
	wire        isolate_now;

	assign ctl_wr = wr_strobe && (reg_addr == `PBCS_CONTROL_REGISTER_INDEX);
	assign isolate_now = mii_isolate_ctl | power_down_ctl;

	// ****************************************
	// management frame slave
	// ****************************************
	pbcs_mdio_slave u_mdio (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.mdc_i       (mdc_i),
		.mdio_i      (mdio_i),
		.mdio_o      (mdio_o),
		.mdio_oe_n_o (mdio_oe_n_o),
		.phy_addr_i  (own_addr),
		.reg_addr_o  (reg_addr),
		.rd_data_i   (rd_data),
		.wr_strobe_o (wr_strobe),
		.wr_data_o   (wr_data)
	);

	// ****************************************
	// control register
	// ****************************************
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			autoneg_enable      <= `PBCS_RST_AUTONEG_ENABLE;
			power_down_ctl      <= `PBCS_RST_POWER_DOWN;
			mii_isolate_ctl     <= `PBCS_RST_MII_ISOLATE;
			restart_autoneg_ctl <= `PBCS_RST_RESTART_AUTONEG;
			duplex_select       <= `PBCS_RST_DUPLEX_SELECT;
			collision_test_ctl  <= `PBCS_RST_COLLISION_TEST;
			strap_taken         <= 1'h0;
			own_addr            <= 5'h00;
			autoneg_restart_o   <= 1'h0;
		end else begin
			autoneg_restart_o <= 1'h0;
			// strap caught once, on the first edge after release
			if (!strap_taken) begin
				strap_taken <= 1'h1;
				own_addr    <= phy_addr_i;
				mii_isolate_ctl <= (phy_addr_i == `PBCS_ISOLATE_STRAP_ADDR);
			end
			if (restart_autoneg_ctl) begin
				restart_autoneg_ctl <= 1'h0;
				autoneg_restart_o   <= 1'h1;
			end
			if (ctl_wr) begin
				autoneg_enable     <= wr_data[`PBCS_CTL_AUTONEG_ENABLE];
				power_down_ctl     <= wr_data[`PBCS_CTL_POWER_DOWN];
				mii_isolate_ctl    <= wr_data[`PBCS_CTL_MII_ISOLATE];
				duplex_select      <= wr_data[`PBCS_CTL_DUPLEX_SELECT];
				collision_test_ctl <= wr_data[`PBCS_CTL_COLLISION_TEST];
				// a new request in the clearing cycle wins over the clear
				if (wr_data[`PBCS_CTL_RESTART_AUTONEG]) begin
					restart_autoneg_ctl <= 1'h1;
				end
			end
		end
	end

	// ****************************************
	// read multiplexer
	// ****************************************
	always @* begin
		control_word = 16'h0000;
		control_word[`PBCS_CTL_AUTONEG_ENABLE]  = autoneg_enable;
		control_word[`PBCS_CTL_POWER_DOWN]      = power_down_ctl;
		control_word[`PBCS_CTL_MII_ISOLATE]     = mii_isolate_ctl;
		control_word[`PBCS_CTL_RESTART_AUTONEG] = restart_autoneg_ctl;
		control_word[`PBCS_CTL_DUPLEX_SELECT]   = duplex_select;
		control_word[`PBCS_CTL_COLLISION_TEST]  = collision_test_ctl;
		case (reg_addr)
			`PBCS_CONTROL_REGISTER_INDEX: begin
				next_rd_data = control_word;
			end
			`PBCS_STATUS_REGISTER_INDEX: begin
				next_rd_data = `PBCS_STATUS_FIXED;
			end
			default: begin
				next_rd_data = 16'h0000;
			end
		endcase
	end

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			rd_data <= 16'h0000;
		end else begin
			rd_data <= next_rd_data;
		end
	end

	// ****************************************
	// mode outputs
	// ****************************************
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			autoneg_enable_o <= `PBCS_RST_AUTONEG_ENABLE;
			full_duplex_o    <= 1'h0;
			power_down_o     <= 1'h0;
			isolated_o       <= 1'h0;
		end else begin
			autoneg_enable_o <= autoneg_enable;
			full_duplex_o    <= autoneg_enable ? an_full_duplex_i : duplex_select;
			power_down_o     <= power_down_ctl;
			isolated_o       <= isolate_now;
		end
	end

	// ****************************************
	// MII, line and indicator steering
	// ****************************************
	// one register stage on every pin; enables follow the same stage so data and float stay aligned
	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			core_txd_o             <= 4'h0;
			core_tx_en_o           <= 1'h0;
			core_tx_er_o           <= 1'h0;
			mii_tx_clk_o           <= 1'h0;
			mii_rx_clk_o           <= 1'h0;
			mii_rxd_o              <= 4'h0;
			mii_rx_dv_o            <= 1'h0;
			mii_rx_er_o            <= 1'h0;
			mii_col_o              <= 1'h0;
			mii_crs_o              <= 1'h0;
			mii_oe_n_o             <= 1'h1;
			line_transmit_pair_p_o <= 1'h0;
			line_transmit_pair_n_o <= 1'h0;
			line_oe_n_o            <= 1'h1;
			led_o                  <= 5'h00;
			led_oe_n_o             <= 1'h1;
		end else begin
			core_txd_o   <= isolate_now ? 4'h0 : mii_txd_i;
			core_tx_en_o <= isolate_now ? 1'h0 : mii_tx_en_i;
			core_tx_er_o <= isolate_now ? 1'h0 : mii_tx_er_i;
			mii_tx_clk_o <= core_tx_clk_i;
			mii_rx_clk_o <= core_rx_clk_i;
			mii_rxd_o    <= core_rxd_i;
			mii_rx_dv_o  <= core_rx_dv_i;
			mii_rx_er_o  <= core_rx_er_i;
			mii_crs_o    <= core_crs_i;
			mii_col_o    <= collision_test_ctl ? mii_tx_en_i : core_col_i;
			mii_oe_n_o   <= isolate_now | ~strap_taken;
			line_transmit_pair_p_o <= core_line_tx_p_i;
			line_transmit_pair_n_o <= core_line_tx_n_i;
			line_oe_n_o  <= power_down_ctl | ~strap_taken;
			led_o        <= core_led_i;
			led_oe_n_o   <= power_down_ctl | ~strap_taken;
		end
	end

endmodule // pbcs_basic_regs
`default_nettype wire

// file: pkg/pbcs_map.vh
// register map, field positions, reset values and frame constants of the basic control/status bank
`ifndef PBCS_MAP_VH
`define PBCS_MAP_VH

// ****************************************
// register indexes
// ****************************************
`define PBCS_CONTROL_REGISTER_INDEX 5'h00
`define PBCS_STATUS_REGISTER_INDEX  5'h01

// ****************************************
// control field positions
// ****************************************
`define PBCS_CTL_AUTONEG_ENABLE      12
`define PBCS_CTL_POWER_DOWN          11
`define PBCS_CTL_MII_ISOLATE         10
`define PBCS_CTL_RESTART_AUTONEG     9
`define PBCS_CTL_DUPLEX_SELECT       8
`define PBCS_CTL_COLLISION_TEST      7

// ****************************************
// reset values
// ****************************************
`define PBCS_RST_AUTONEG_ENABLE      1'h1
`define PBCS_RST_POWER_DOWN          1'h0
`define PBCS_RST_MII_ISOLATE         1'h0
`define PBCS_RST_RESTART_AUTONEG     1'h0
`define PBCS_RST_DUPLEX_SELECT       1'h0
`define PBCS_RST_COLLISION_TEST      1'h0

// ****************************************
// fixed status word: bit15 four-pair 0, bits 14..11 abilities 1, rest 0
// ****************************************
`define PBCS_STATUS_FIXED            16'h7800
`define PBCS_ISOLATE_STRAP_ADDR      5'h00

// ****************************************
// management frame
// ****************************************
`define PBCS_OP_READ                 2'h2
`define PBCS_OP_WRITE                2'h1
`define PBCS_ADDR_BITS               4'h9
`define PBCS_DATA_BITS               4'hf

`endif

// file: rtl/pbcs_mdio_slave.v
// serial management frame slave: decodes frames sampled from mdc, returns read data, strobes writes
`timescale 1ns/100ps
`default_nettype none
`include "pbcs_map.vh"

module pbcs_mdio_slave (
	// clock and reset
	input  wire        clock_i,
	input  wire        rst_n_i,
	// serial management pins
	input  wire        mdc_i,
	input  wire        mdio_i,
	output reg         mdio_o,
	output reg         mdio_oe_n_o,
	// own address
	input  wire [4:0]  phy_addr_i,
	// register side
	output reg  [4:0]  reg_addr_o,
	input  wire [15:0] rd_data_i,
	output reg         wr_strobe_o,
	output reg  [15:0] wr_data_o
);

	// ****************************************
	// states
	// ****************************************
	localparam ST_IDLE  = 3'h0;
	localparam ST_START = 3'h1;
	localparam ST_OP    = 3'h2;
	localparam ST_ADDR  = 3'h3;
	localparam ST_TA    = 3'h4;
	localparam ST_DATA  = 3'h5;

	reg  [2:0]  state;
	reg  [3:0]  cnt;
	reg  [15:0] sh;
	reg  [1:0]  op;
	reg         hit;
	reg  [16:0] out_sh;
	reg         drv;
	reg         release_pend;
	reg         mdc_q;
	reg         mdc_prev;
	reg         mdio_q;
	wire        rise;
	wire        fall;
	wire [15:0] sh_in;

	assign rise  = mdc_q & ~mdc_prev;
	assign fall  = ~mdc_q & mdc_prev;
	assign sh_in = {sh[14:0], mdio_q};

	always @(posedge clock_i) begin
		if (!rst_n_i) begin
			// idle level of mdc is high: avoids a false rise after reset
			mdc_q        <= 1'h1;
			mdc_prev     <= 1'h1;
			mdio_q       <= 1'h1;
			state        <= ST_IDLE;
			cnt          <= 4'h0;
			sh           <= 16'h0000;
			op           <= 2'h0;
			hit          <= 1'h0;
			out_sh       <= 17'h00000;
			drv          <= 1'h0;
			release_pend <= 1'h0;
			mdio_o       <= 1'h1;
			mdio_oe_n_o  <= 1'h1;
			reg_addr_o   <= 5'h00;
			wr_strobe_o  <= 1'h0;
			wr_data_o    <= 16'h0000;
		end else begin
			mdc_q       <= mdc_i;
			mdc_prev    <= mdc_q;
			mdio_q      <= mdio_i;
			wr_strobe_o <= 1'h0;
			if (rise) begin
				case (state)
					ST_IDLE: begin
						// preamble may be suppressed: any 0 after idle opens a frame
						if (!mdio_q) begin
							state <= ST_START;
						end
					end
					ST_START: begin
						state <= mdio_q ? ST_OP : ST_IDLE;
						cnt   <= 4'h0;
					end
					ST_OP: begin
						op  <= {op[0], mdio_q};
						cnt <= cnt + 4'h1;
						if (cnt == 4'h1) begin
							state <= ST_ADDR;
							cnt   <= 4'h0;
						end
					end
					ST_ADDR: begin
						sh  <= sh_in;
						cnt <= cnt + 4'h1;
						if (cnt == `PBCS_ADDR_BITS) begin
							reg_addr_o <= sh_in[4:0];
							hit        <= (sh_in[9:5] == phy_addr_i);
							state      <= ST_TA;
							cnt        <= 4'h0;
						end
					end
					ST_TA: begin
						cnt <= cnt + 4'h1;
						if (cnt == 4'h0) begin
							if (hit && (op == `PBCS_OP_READ)) begin
								drv    <= 1'h1;
								out_sh <= {1'h0, rd_data_i};
							end
						end else begin
							state <= ST_DATA;
							cnt   <= 4'h0;
						end
					end
					ST_DATA: begin
						sh  <= sh_in;
						cnt <= cnt + 4'h1;
						if (cnt == `PBCS_DATA_BITS) begin
							state <= ST_IDLE;
							if (drv) begin
								release_pend <= 1'h1;
							end
							if (hit && (op == `PBCS_OP_WRITE)) begin
								wr_strobe_o <= 1'h1;
								wr_data_o   <= sh_in;
							end
						end
					end
					default: begin
						state <= ST_IDLE;
					end
				endcase
			end
			// read data changes on the falling mdc edge so the station samples it stable
			if (fall && drv) begin
				if (release_pend) begin
					drv          <= 1'h0;
					release_pend <= 1'h0;
					mdio_oe_n_o  <= 1'h1;
					mdio_o       <= 1'h1;
				end else begin
					mdio_o      <= out_sh[16];
					mdio_oe_n_o <= 1'h0;
					out_sh      <= {out_sh[15:0], 1'h0};
				end
			end
		end
	end

endmodule // pbcs_mdio_slave
`default_nettype wire

// file: tb/pbcs_basic_regs_props.sv
// assertion checker bound to the basic control and status bank
`timescale 1ns/100ps
`default_nettype none

module pbcs_basic_regs_props (
	// clock and reset
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	// watched pins
	input wire logic       led_oe_n_o,
	input wire logic       line_oe_n_o,
	input wire logic       mii_oe_n_o,
	input wire logic [3:0] core_txd_o,
	input wire logic       core_tx_en_o,
	input wire logic       core_tx_er_o,
	input wire logic       mdio_o,
	input wire logic       mdio_oe_n_o,
	input wire logic       an_full_duplex_i,
	input wire logic       autoneg_enable_o,
	input wire logic       autoneg_restart_o,
	input wire logic       full_duplex_o,
	input wire logic       power_down_o,
	input wire logic       isolated_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);

	// ****************************************
	// sequences
	// ****************************************
	sequence s_restart_quiet;
		!autoneg_restart_o [*4];
	endsequence
	// a read answer lasts 17 mdc bits, far above 8 cycles
	sequence s_read_drive;
		!mdio_oe_n_o [*8];
	endsequence

	// ****************************************
	// properties
	// ****************************************
	a_pd_isolates: assert property (power_down_o |-> isolated_o)
		else $error("power-down without isolation");
	a_pd_floats: assert property (power_down_o && $past(power_down_o) |-> line_oe_n_o && led_oe_n_o)
		else $error("line or indicators driven in power-down");
	a_iso_floats: assert property (isolated_o && $past(isolated_o) |-> mii_oe_n_o)
		else $error("mii driven while isolated");
	a_iso_tx_quiet: assert property (isolated_o && $past(isolated_o)
		|-> !core_tx_en_o && !core_tx_er_o && core_txd_o == 4'h0)
		else $error("transmit input passed while isolated");
	a_restart_pulse: assert property (autoneg_restart_o |=> s_restart_quiet)
		else $error("restart pulse too long");
	a_duplex_auto: assert property ($past(rst_n_i) && autoneg_enable_o && $past(autoneg_enable_o)
		&& $past(autoneg_enable_o, 2) |-> full_duplex_o == $past(an_full_duplex_i))
		else $error("duplex not from negotiation");
	a_ta_zero: assert property ($fell(mdio_oe_n_o) |-> ##[0:1] !mdio_o)
		else $error("turnaround not driven low");
	a_read_hold: assert property ($fell(mdio_oe_n_o) |-> s_read_drive)
		else $error("read answer cut short");
endmodule // pbcs_basic_regs_props

bind pbcs_basic_regs pbcs_basic_regs_props u_props (
	.clock_i, .rst_n_i, .led_oe_n_o, .line_oe_n_o, .mii_oe_n_o, .core_txd_o, .core_tx_en_o,
	.core_tx_er_o, .mdio_o, .mdio_oe_n_o, .an_full_duplex_i, .autoneg_enable_o, .autoneg_restart_o,
	.full_duplex_o, .power_down_o, .isolated_o
);
`default_nettype wire

// file: tb/pbcs_mac_model.sv
// management master of the mac side, making mdc and its half of mdio
`timescale 1ns/100ps
`default_nettype none
`include "pbcs_map.vh"

module pbcs_mac_model (
	// clock
	input  wire logic clock_i,
	// management wire level
	input  wire logic mdio_i,
	output var logic  mdc_o,
	output var logic  mdio_o,
	output var logic  mdio_oe_n_o
);
	initial begin
		mdc_o = 1'b1;
		mdio_o = 1'b1;
		mdio_oe_n_o = 1'b1;
	end

	// one frame, no preamble, closed by one released idle bit
	task automatic mgmt(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] fr;
		fr = {2'b01, op, pa, ra, 2'b10, wd};
		for (int i = 31; i >= -1; i--) begin
			@(negedge clock_i);
			mdc_o = 1'b0;
			// released for the read turnaround and data
			mdio_oe_n_o = (i < 0) || (op == `PBCS_OP_READ && i < 18);
			mdio_o = (i < 0) ? 1'b1 : fr[i];
			repeat (4) @(negedge clock_i);
			mdc_o = 1'b1;
			if (i >= 0 && i < 16)
				rd[i] = mdio_i;
			repeat (3) @(negedge clock_i);
		end
	endtask
endmodule // pbcs_mac_model
`default_nettype wire

// file: tb/phy_basic_control_status_test.sv
// self-checking bench of the basic control and status bank
`timescale 1ns/100ps
`default_nettype none
`include "pbcs_map.vh"

module phy_basic_control_status_test;
	logic        clock_i;
	logic        rst_n_i;
	logic        mii_tx_en_i;
	logic        an_full_duplex_i;
	logic [4:0]  phy_addr_i;
	logic [4:0]  strap;
	logic [31:0] rnd;
	logic [15:0] rdat;
	logic [15:0] wq [$];
	logic [15:0] pulses = 16'h0000;
	int          exp_pulses = 0;
	int          err_total = 0;
	int          total_checks = 0;
	int          cyc = 0;
	wire logic   mdc, mdio_w, mac_d, mac_oe_n, phy_d, phy_oe_n, core_tx_en_o, mii_col_o, mii_oe_n_o;
	wire logic   line_oe_n_o, led_oe_n_o, autoneg_enable_o, autoneg_restart_o, full_duplex_o;
	wire logic   power_down_o, isolated_o;

	// pulled-up wire: whoever is enabled, else high
	assign mdio_w = !phy_oe_n ? phy_d : (!mac_oe_n ? mac_d : 1'b1);

	pbcs_basic_regs u_pbcs_basic_regs (
		.clock_i(clock_i), .rst_n_i(rst_n_i), .phy_addr_i(phy_addr_i), .mdc_i(mdc), .mdio_i(mdio_w),
		.mdio_o(phy_d), .mdio_oe_n_o(phy_oe_n), .mii_txd_i(rnd[10:7]), .mii_tx_en_i(mii_tx_en_i),
		.mii_tx_er_i(rnd[11]), .core_txd_o(), .core_tx_en_o(core_tx_en_o), .core_tx_er_o(),
		.core_tx_clk_i(rnd[12]), .core_rx_clk_i(rnd[13]), .core_rxd_i(rnd[17:14]), .core_rx_dv_i(rnd[18]),
		.core_rx_er_i(rnd[19]), .core_col_i(rnd[20]), .core_crs_i(rnd[21]), .mii_tx_clk_o(),
		.mii_rx_clk_o(), .mii_rxd_o(), .mii_rx_dv_o(), .mii_rx_er_o(), .mii_col_o(mii_col_o), .mii_crs_o(),
		.mii_oe_n_o(mii_oe_n_o), .core_line_tx_p_i(rnd[5]), .core_line_tx_n_i(rnd[6]),
		.line_transmit_pair_p_o(), .line_transmit_pair_n_o(), .line_oe_n_o(line_oe_n_o),
		.core_led_i(rnd[4:0]), .led_o(), .led_oe_n_o(led_oe_n_o), .an_full_duplex_i(an_full_duplex_i),
		.autoneg_enable_o(autoneg_enable_o), .autoneg_restart_o(autoneg_restart_o),
		.full_duplex_o(full_duplex_o), .power_down_o(power_down_o), .isolated_o(isolated_o)
	);
	pbcs_mac_model mac (.clock_i(clock_i), .mdio_i(mdio_w), .mdc_o(mdc), .mdio_o(mac_d), .mdio_oe_n_o(mac_oe_n));

	// ****************************************
	// clock, noise on core inputs, pulse count, time limit
	// ****************************************
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	always @(negedge clock_i) rnd <= $urandom;
	always @(posedge clock_i) begin
		cyc <= cyc + 1;
		if (autoneg_restart_o === 1'b1)
			pulses <= pulses + 16'h0001;
		if (cyc == 40000) begin
			err_total++;
			end_sim;
		end
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic chk(input logic [15:0] seen, input logic [15:0] want);
		total_checks++;
		if (seen !== want) begin
			err_total++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask
	task automatic acc(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd);
		mac.mgmt(op, strap, ra, wd, rdat);
	endtask
	task automatic do_reset(input logic [4:0] a);
		strap = a;
		phy_addr_i = a;
		rst_n_i = 1'b0;
		repeat (4) @(negedge clock_i);
		rst_n_i = 1'b1;
		repeat (4) @(negedge clock_i);
	endtask
	// one control write, a stray write to another address, then readback and pin checks
	task automatic step(input logic [15:0] wv);
		logic [15:0] e;
		e = wv & 16'h1d80;
		an_full_duplex_i = rnd[22];
		acc(`PBCS_OP_WRITE, `PBCS_CONTROL_REGISTER_INDEX, wv);
		mac.mgmt(`PBCS_OP_WRITE, strap ^ 5'h01, `PBCS_CONTROL_REGISTER_INDEX, ~wv, rdat);
		exp_pulses += wv[9];
		acc(`PBCS_OP_READ, `PBCS_CONTROL_REGISTER_INDEX, 16'h0000);
		chk(rdat, e);
		chk(pulses, 16'(exp_pulses));
		chk(power_down_o, e[11]);
		chk({line_oe_n_o, led_oe_n_o}, {2{e[11]}});
		chk({isolated_o, mii_oe_n_o}, {2{e[11] | e[10]}});
		chk(autoneg_enable_o, e[12]);
		chk(full_duplex_o, e[12] ? an_full_duplex_i : e[8]);
		mii_tx_en_i = 1'b1;
		repeat (2) @(negedge clock_i);
		chk(core_tx_en_o, !(e[11] | e[10]));
		if (e[7]) chk(mii_col_o, 1'b1);
		mii_tx_en_i = 1'b0;
		repeat (2) @(negedge clock_i);
		if (e[7]) chk(mii_col_o, 1'b0);
		acc(`PBCS_OP_WRITE, `PBCS_STATUS_REGISTER_INDEX, wv);
		acc(`PBCS_OP_READ, `PBCS_STATUS_REGISTER_INDEX, 16'h0000);
		chk(rdat[15], 1'b0);
		chk(rdat[14:13], 2'b11);
		chk(rdat[12:11], 2'b11);
		chk(rdat[10:0], 11'h000);
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rnd = $urandom(32'hd535);
		mii_tx_en_i = 1'b0;
		an_full_duplex_i = 1'b0;
		do_reset(5'($urandom_range(31, 1)));
		acc(`PBCS_OP_READ, `PBCS_CONTROL_REGISTER_INDEX, 16'h0000);
		chk(rdat, 16'h1000);
		wq = '{16'hffff, 16'h0000, 16'h0400, 16'h0100, 16'h1200, 16'h0080, 16'h1100, 16'h0800};
		repeat (4) wq.push_back(16'($urandom));
		foreach (wq[k]) step(wq[k]);
		// all-zero strap comes up isolated
		do_reset(5'h00);
		acc(`PBCS_OP_READ, `PBCS_CONTROL_REGISTER_INDEX, 16'h0000);
		chk(rdat, 16'h1400);
		chk(isolated_o, 1'b1);
		step(16'h1000);
		end_sim;
	end
endmodule // phy_basic_control_status_test
`default_nettype wire
